// File: rtl/rlp_ctrl.sv
// Purpose: line protocol control with redundancy handling
// Assumes: link clock is sampled, symbols taken on its rising edge
// Notes:   symbol {qual,data}: 01 idle/stop, 10 start, 11 start flag
module rlp_ctrl
    import rlp_pkg::*;
#(
    parameter int RST_CNT_W = 8
) (
    // clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        SYS_RST_I,
    // register port
    input  wire logic [15:0] ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    // system pins
    input  wire logic        MASTER_SELECT_N_I,
    input  wire logic        CPU_NOT_READY_N_I,
    input  wire logic        FAULT_DETECT_I,
    output logic             SWOVER_ENABLE_N_O,
    output logic             FAULT_N_O,
    output logic             LINE_DISABLE_N_O,
    output logic             DMA_ENABLE_O,
    // resets
    output logic             POWERON_RESET_N_O,
    output logic             FAST_FIFO_RESET_RX_O,
    output logic             FAST_FIFO_RESET_TX_O,
    output logic             LOGIC_RESET_O,
    // link, {qual,data} per redundant line
    input  wire logic        LINK_CLK_I,
    input  wire logic [1:0]  LINE_A_I,
    output logic      [1:0]  LINE_A_O,
    output logic             LINE_A_OE_O,
    input  wire logic [1:0]  LINE_B_I,
    output logic      [1:0]  LINE_B_O,
    output logic             LINE_B_OE_O,
    output logic             XFER_ERROR_O
);

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        logic                 lk_s1;
        logic                 lk_s2;
        logic                 lk_d;
        logic [1:0]           a_s1;
        logic [1:0]           a_s2;
        logic [1:0]           b_s1;
        logic [1:0]           b_s2;
        logic                 ms_s1;
        logic                 ms_s2;
        logic                 nr_s1;
        logic                 nr_s2;
        logic                 fd_s1;
        logic                 fd_s2;
        logic                 master;
        logic [RST_CNT_W-1:0] rst_cnt;
        logic                 logic_rst;
        logic                 por_n;
        logic                 param;
        logic                 swover;
        logic                 fault;
        logic                 bus_sel;
        rlp_xfer_t            rx_st;
        logic                 err;
        logic                 tx_busy;
        logic                 tx_drv;
        logic [1:0]           tx_sym;
        logic [1:0]           line_out;
        logic                 line_oe;
        logic                 clr_rx;
        logic                 clr_tx;
        logic [7:0]           rdata;
    } rlp_state_t;

    rlp_state_t st;
    rlp_state_t next_st;

    localparam logic [RST_CNT_W-1:0] RST_LOAD =
        RST_CNT_W'(RST_PULSE_CYC);

    // ****************************************************
    // receiver transition
    // ****************************************************
    // one sampled symbol {qual,data} moves the protocol state
    function automatic rlp_xfer_t rx_next(input rlp_xfer_t s,
                                          input logic [1:0] sym);
        rlp_xfer_t n;
        n = s;
        unique case (s)
            XFER_RESET_STATE: begin
                if (sym == 2'b01) n = XFER_IDLE_STATE;
            end
            XFER_IDLE_STATE: begin
                if (sym == 2'b10) n = XFER_WAIT_STATE;
                else if (sym != 2'b01) n = XFER_ABORT_STATE;
            end
            XFER_WAIT_STATE: begin
                if (sym == 2'b10) n = XFER_DATA_STATE;
                else if (sym == 2'b11) n = XFER_FLAG_STATE;
                else if (sym == 2'b01) n = XFER_IDLE_STATE;
                else n = XFER_ABORT_STATE;
            end
            XFER_DATA_STATE: begin
                if (sym == 2'b10) n = XFER_WAIT_STATE;
                else if (sym == 2'b11) n = XFER_ABORT_STATE;
            end
            XFER_FLAG_STATE: begin
                if (sym == 2'b11) n = XFER_WAIT_STATE;
                else if (sym == 2'b10) n = XFER_ABORT_STATE;
            end
            XFER_ABORT_STATE: n = XFER_ABORT_STATE;
            default: n = XFER_RESET_STATE;
        endcase
        return n;
    endfunction

    // ****************************************************
    // next state
    // ****************************************************
    logic       standby;
    logic       basic;
    logic       lk_rise;
    logic       lk_fall;
    logic [1:0] line_sym;
    logic [1:0] rx_sym;
    logic       acc_ctrl;
    logic       tx_ok;

    always_comb begin
        next_st = st;

        // two-stage synchronisers for everything off this clock
        next_st.lk_s1 = LINK_CLK_I;
        next_st.lk_s2 = st.lk_s1;
        next_st.lk_d  = st.lk_s2;
        next_st.a_s1  = LINE_A_I;
        next_st.a_s2  = st.a_s1;
        next_st.b_s1  = LINE_B_I;
        next_st.b_s2  = st.b_s1;
        next_st.ms_s1 = MASTER_SELECT_N_I;
        next_st.ms_s2 = st.ms_s1;
        next_st.nr_s1 = CPU_NOT_READY_N_I;
        next_st.nr_s2 = st.nr_s1;
        next_st.fd_s1 = FAULT_DETECT_I;
        next_st.fd_s2 = st.fd_s1;

        lk_rise  = st.lk_s2 & ~st.lk_d;
        lk_fall  = ~st.lk_s2 & st.lk_d;
        standby  = ~st.master;
        line_sym = st.bus_sel ? st.b_s2 : st.a_s2;
        // own data when sending or coupled internally
        rx_sym   = (st.tx_drv | standby) ? st.tx_sym : line_sym;

        // mode change starts the reset pulse
        next_st.master = ~st.ms_s2;
        next_st.por_n  = 1'b1;
        if (st.master != ~st.ms_s2) begin
            next_st.rst_cnt = RST_LOAD;
        end else if (st.rst_cnt != '0) begin
            next_st.rst_cnt = st.rst_cnt - 1'b1;
        end
        basic = (st.rst_cnt != '0) | (st.master != ~st.ms_s2)
              | st.nr_s2;
        next_st.logic_rst = basic;

        // fault from self-test or watchdog holds until power-on
        if (st.fd_s2) next_st.fault = 1'b1;

        // fast fifo resets, one cycle each
        next_st.clr_rx = WR_I & (ADDR_I == FIFO_CLR_ADDR);
        next_st.clr_tx = RD_I & (ADDR_I == FIFO_CLR_ADDR);

        // switchover enable location
        if (WR_I && ADDR_I == SWOVER_ADDR) begin
            if (WDATA_I == SWOVER_SET) next_st.swover = 1'b1;
            else if (WDATA_I == SWOVER_CLR) next_st.swover = 1'b0;
        end

        // receiver samples on link clock rise, command next step
        if (lk_rise) begin
            next_st.rx_st = rx_next(st.rx_st, rx_sym);
            if (st.tx_drv) begin
                next_st.tx_busy = 1'b0;
                next_st.tx_drv  = 1'b0;
                // bit by bit read-back of what was sent
                if (!standby && line_sym != st.tx_sym) begin
                    next_st.rx_st = XFER_ABORT_STATE;
                end
            end
        end
        if (next_st.rx_st == XFER_ABORT_STATE) next_st.err = 1'b1;

        // transmitter drives on link clock fall
        if (lk_fall) begin
            if (st.tx_busy) begin
                next_st.tx_drv   = 1'b1;
                next_st.line_out = st.tx_sym;
                next_st.line_oe  = ~standby & ~st.fault;
            end else begin
                next_st.line_oe  = 1'b0;
            end
        end
        if (standby || st.fault) next_st.line_oe = 1'b0;

        // control word
        acc_ctrl = WR_I & (ADDR_I == CTRL_ADDR);
        // transmit accepted only when receiver is in a live state
        tx_ok = ~st.tx_busy & (st.rx_st != XFER_RESET_STATE)
              & (st.rx_st != XFER_ABORT_STATE);
        if (acc_ctrl) begin
            next_st.bus_sel = WDATA_I[CTRL_BUS_SEL];
            if (WDATA_I[CTRL_PARAM]) next_st.param = 1'b1;
            if (WDATA_I[CTRL_SEND] && tx_ok) begin
                next_st.tx_busy = 1'b1;
                next_st.tx_sym  = {WDATA_I[CTRL_TX_QUAL],
                                   WDATA_I[CTRL_TX_DATA]};
            end
            if (WDATA_I[CTRL_RESET]) begin
                next_st.rx_st = XFER_RESET_STATE;
                next_st.err   = 1'b0;
            end
        end

        // basic state clears the protocol and parameterisation
        if (basic) begin
            next_st.rx_st   = XFER_RESET_STATE;
            next_st.err     = 1'b0;
            next_st.tx_busy = 1'b0;
            next_st.tx_drv  = 1'b0;
            next_st.line_oe = 1'b0;
            next_st.param   = 1'b0;
            next_st.swover  = 1'b0;
        end

        // read data stands in the cycle after the strobe
        next_st.rdata = 8'h00;
        if (RD_I && ADDR_I == STAT_ADDR) begin
            next_st.rdata[STAT_STATE +: 3] = st.rx_st;
            next_st.rdata[STAT_BUSY]   = st.tx_busy;
            next_st.rdata[STAT_MASTER] = st.master;
            next_st.rdata[STAT_FAULT]  = st.fault;
            next_st.rdata[STAT_SWOVER] = st.swover;
            next_st.rdata[STAT_PARAM]  = st.param;
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    // power-on values; master flag starts as standby until sampled
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            st           <= '0;
            st.rx_st     <= XFER_RESET_STATE;
            st.rst_cnt   <= RST_LOAD;
            st.logic_rst <= 1'b1;
            st.ms_s1     <= 1'b1;
            st.ms_s2     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************
    // outputs from flip-flops; LINE_DISABLE_N_O and DMA_ENABLE_O each gate two of them
    // ****************************************************
    assign RDATA_O              = st.rdata;
    assign SWOVER_ENABLE_N_O    = ~st.swover;
    assign FAULT_N_O            = ~st.fault;
    assign LINE_DISABLE_N_O     = st.master & ~st.fault;
    assign DMA_ENABLE_O         = st.master & st.param;
    assign POWERON_RESET_N_O    = st.por_n;
    assign FAST_FIFO_RESET_RX_O = st.clr_rx;
    assign FAST_FIFO_RESET_TX_O = st.clr_tx;
    assign LOGIC_RESET_O        = st.logic_rst;
    // both transceivers driven alike in active mode
    assign LINE_A_O             = st.line_out;
    assign LINE_A_OE_O          = st.line_oe;
    assign LINE_B_O             = st.line_out;
    assign LINE_B_OE_O          = st.line_oe;
    assign XFER_ERROR_O         = st.err;

endmodule // rlp_ctrl

// File: shared/rlp_pkg.sv
// Purpose: constants and types of the line protocol controller
// Assumes: 100 MHz system clock, 16-bit address, 8-bit data port
// Notes:   all offsets, fields, resets and timing counts live here
package rlp_pkg;

    // ****************************************************
    // register map
    // ****************************************************
    localparam logic [15:0] SWOVER_ADDR  = 16'h4d00; // write only
    localparam logic [15:0] CTRL_ADDR    = 16'h4d01; // write only
    localparam logic [15:0] STAT_ADDR    = 16'h4d02; // read only
    localparam logic [15:0] FIFO_CLR_ADDR = 16'hfc07; // wr rx, rd tx
    localparam logic [7:0]  SWOVER_SET   = 8'h01;
    localparam logic [7:0]  SWOVER_CLR   = 8'h00;

    // ****************************************************
    // control word fields
    // ****************************************************
    localparam int CTRL_TX_DATA = 0; // symbol data bit
    localparam int CTRL_TX_QUAL = 1; // symbol qualifier bit
    localparam int CTRL_SEND    = 2; // queue the symbol
    localparam int CTRL_RESET   = 3; // reset command, leaves abort
    localparam int CTRL_PARAM   = 4; // mark unit parameterised
    localparam int CTRL_BUS_SEL = 5; // receive from line b when 1

    // ****************************************************
    // status word fields
    // ****************************************************
    localparam int STAT_STATE  = 0; // bits 2..0
    localparam int STAT_BUSY   = 3;
    localparam int STAT_MASTER = 4;
    localparam int STAT_FAULT  = 5;
    localparam int STAT_SWOVER = 6;
    localparam int STAT_PARAM  = 7;

    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_NS        = 10;
    localparam int RST_PULSE_NS  = 1000;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;

    // ****************************************************
    // protocol states
    // ****************************************************
    typedef enum logic [2:0] {
        XFER_RESET_STATE,
        XFER_IDLE_STATE,
        XFER_WAIT_STATE,
        XFER_DATA_STATE,
        XFER_FLAG_STATE,
        XFER_ABORT_STATE
    } rlp_xfer_t;

endpackage

// File: tb/rlp_ctrl_sva.sv
// Purpose: port level checks of the line protocol controller
// Assumes: one clock domain, synchronous active high reset
// Notes:   bound to every rlp_ctrl instance at the foot of this file
module rlp_ctrl_sva
    import rlp_pkg::*;
(
    // clock and reset
    input wire logic        CLOCK_I,
    input wire logic        SYS_RST_I,
    // register port
    input wire logic [15:0] ADDR_I,
    input wire logic [7:0]  WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    // system pins
    input wire logic        MASTER_SELECT_N_I,
    input wire logic        CPU_NOT_READY_N_I,
    input wire logic        SWOVER_ENABLE_N_O,
    input wire logic        FAULT_N_O,
    input wire logic        LINE_DISABLE_N_O,
    input wire logic        DMA_ENABLE_O,
    // resets and link
    input wire logic        FAST_FIFO_RESET_RX_O,
    input wire logic        FAST_FIFO_RESET_TX_O,
    input wire logic        LOGIC_RESET_O,
    input wire logic        LINE_A_OE_O,
    input wire logic        LINE_B_OE_O,
    input wire logic        XFER_ERROR_O
);
    // ****************************************************
    // helper logic and checks
    // ****************************************************
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);
    int basic_cnt;  // length of the current basic state
    logic nr_seen;  // not-ready held this basic state, any length allowed

    // count the cycles of each basic state pulse
    always_ff @(posedge CLOCK_I) begin
        basic_cnt <= (SYS_RST_I || !LOGIC_RESET_O) ? 0 : basic_cnt + 1;
    end

    // note a not-ready hold, which ends the basic state at its own pace
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            nr_seen <= 1'b0;
        end else if (CPU_NOT_READY_N_I) begin
            nr_seen <= 1'b1;
        end else if (!LOGIC_RESET_O) begin
            nr_seen <= 1'b0;
        end
    end

    sequence s_sw_set;
        WR_I && ADDR_I == SWOVER_ADDR && WDATA_I == SWOVER_SET
            && !LOGIC_RESET_O;
    endsequence
    sequence s_sw_clr;
        WR_I && ADDR_I == SWOVER_ADDR && WDATA_I == SWOVER_CLR;
    endsequence
    sequence s_to_standby;
        !MASTER_SELECT_N_I ##1 MASTER_SELECT_N_I;
    endsequence

    a_swover_set: assert property (
        s_sw_set |=> !SWOVER_ENABLE_N_O || LOGIC_RESET_O)
        else $error("switchover enable not set");
    a_swover_clr: assert property (
        s_sw_clr |=> SWOVER_ENABLE_N_O)
        else $error("switchover enable not cleared");
    a_fifo_clear: assert property (
        (WR_I || RD_I) && ADDR_I == FIFO_CLR_ADDR |=>
        FAST_FIFO_RESET_RX_O == $past(WR_I)
        && FAST_FIFO_RESET_TX_O == $past(RD_I))
        else $error("fifo clear pulse wrong");
    a_abort_hold: assert property (
        XFER_ERROR_O && !LOGIC_RESET_O
        && !(WR_I && ADDR_I == CTRL_ADDR && WDATA_I[CTRL_RESET])
        |=> XFER_ERROR_O || LOGIC_RESET_O)
        else $error("abort left without reset command");
    a_basic_hold: assert property (
        CPU_NOT_READY_N_I [*6] |-> LOGIC_RESET_O)
        else $error("basic state not held");
    a_to_standby: assert property (
        s_to_standby |-> ##[1:8] LOGIC_RESET_O)
        else $error("no reset on change to standby");
    a_pulse_len: assert property (
        $fell(LOGIC_RESET_O) && !nr_seen |-> basic_cnt >= 99)
        else $error("basic state pulse too short");
    a_standby_quiet: assert property (
        !LINE_DISABLE_N_O |=> !LINE_A_OE_O && !LINE_B_OE_O)
        else $error("line driven while disabled");
    a_fault_off: assert property (
        !FAULT_N_O |=> !LINE_DISABLE_N_O && !LINE_A_OE_O && !LINE_B_OE_O)
        else $error("line driven after fault");
    a_standby_role: assert property (
        MASTER_SELECT_N_I [*8] |-> !LINE_DISABLE_N_O && !DMA_ENABLE_O)
        else $error("standby unit still active");
endmodule // rlp_ctrl_sva

bind rlp_ctrl rlp_ctrl_sva u_sva (.*);

// File: tb/rlp_line_model.sv
// Purpose: far side of the local bus and the role couplers
// Assumes: line released by the far side while the block drives it
// Notes:   link clock stands still high between symbols
module rlp_line_model (
    // role coupler
    input  wire logic       clk_i,
    input  wire logic       swap_i,
    input  wire logic       swover_n_i,
    output logic            master_n_o,
    // link lines
    output logic            link_clk_o,
    output logic [1:0]      line_a_o,
    output logic [1:0]      line_b_o,
    input  wire logic [1:0] dut_a_i,
    input  wire logic       dut_a_oe_i,
    input  wire logic [1:0] dut_b_i,
    input  wire logic       dut_b_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] sym = 2'b00;  // symbol put on the line by the far side

    initial link_clk_o = 1'b1;
    initial master_n_o = 1'b0;
    // the far side stays silent while the block transmits
    assign line_a_o = dut_a_oe_i ? dut_a_i : sym;
    assign line_b_o = dut_b_oe_i ? dut_b_i : sym;

    // one link period per symbol, legal order chosen by the caller
    task automatic send(input logic [1:0] s);
        link_clk_o = 1'b0;
        sym = s;
        #62.5;
        link_clk_o = 1'b1;
        #62.5;
        sym = ~s;  // hold time over, the line no longer shows s
    endtask

    // couplers swap roles only while switchover is enabled
    always @(posedge clk_i) begin
        if (swap_i && !swover_n_i) begin
            master_n_o <= ~master_n_o;
        end
    end
endmodule // rlp_line_model

// File: tb/test_rlp_ctrl.sv
// Purpose: self checking bench of the line protocol controller
// Assumes: 100 MHz clock, link period 125 ns from the line model
// Notes:   one task per scenario, verdict printed by give_verdict
module test_rlp_ctrl
    import rlp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, wr, rd, cpu_nrdy_n, fault, swap, swover_n;
    logic        fault_n, dis_n, dma, por_n, rx_clr, tx_clr, basic;
    logic        lclk, err, master_n, la_oe, lb_oe;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, d;
    logic [1:0]  la_i, lb_i, la_o, lb_o;
    int          failures = 0, comparisons = 0, n;
    // tx flag, symbol {qual,data}, state expected afterwards
    localparam logic [5:0] STEPS [15] = '{
        {3'b001, XFER_IDLE_STATE}, {3'b010, XFER_WAIT_STATE},
        {3'b010, XFER_DATA_STATE}, {3'b000, XFER_DATA_STATE},
        {3'b010, XFER_WAIT_STATE}, {3'b011, XFER_FLAG_STATE},
        {3'b011, XFER_WAIT_STATE}, {3'b001, XFER_IDLE_STATE},
        {3'b110, XFER_WAIT_STATE}, {3'b111, XFER_FLAG_STATE},
        {3'b111, XFER_WAIT_STATE}, {3'b101, XFER_IDLE_STATE},
        {3'b011, XFER_ABORT_STATE}, {3'b001, XFER_ABORT_STATE},
        {3'b010, XFER_ABORT_STATE}};

    rlp_ctrl u_dut (
        .CLOCK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .MASTER_SELECT_N_I(master_n), .CPU_NOT_READY_N_I(cpu_nrdy_n),
        .FAULT_DETECT_I(fault), .SWOVER_ENABLE_N_O(swover_n),
        .FAULT_N_O(fault_n), .LINE_DISABLE_N_O(dis_n), .DMA_ENABLE_O(dma),
        .POWERON_RESET_N_O(por_n), .FAST_FIFO_RESET_RX_O(rx_clr),
        .FAST_FIFO_RESET_TX_O(tx_clr), .LOGIC_RESET_O(basic),
        .LINK_CLK_I(lclk), .LINE_A_I(la_i), .LINE_A_O(la_o),
        .LINE_A_OE_O(la_oe), .LINE_B_I(lb_i), .LINE_B_O(lb_o),
        .LINE_B_OE_O(lb_oe), .XFER_ERROR_O(err));
    rlp_line_model u_line (
        .clk_i(clk), .swap_i(swap), .swover_n_i(swover_n),
        .master_n_o(master_n), .link_clk_o(lclk), .line_a_o(la_i),
        .line_b_o(lb_i), .dut_a_i(la_o), .dut_a_oe_i(la_oe),
        .dut_b_i(lb_o), .dut_b_oe_i(lb_oe));

    // ****************************************************
    // bus cycles and helpers
    // ****************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // let the basic state begin, then count its cycles up to its end
    task automatic wait_basic();
        repeat (8) @(posedge clk);
        n = 0;
        while (basic && n < 400) begin
            @(posedge clk);
            #1 n++;
        end
        check(8'(basic), 8'h00);
    endtask
    task automatic swap_roles();
        wr_reg(SWOVER_ADDR, SWOVER_SET);
        @(posedge clk) swap <= 1'b1;
        @(posedge clk) swap <= 1'b0;
        wait_basic();
        check(8'(n >= 90), 8'h01);
    endtask

    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_regs();
        check(8'(swover_n), 8'h01);
        wr_reg(SWOVER_ADDR, SWOVER_SET);
        check(8'(swover_n), 8'h00);
        wr_reg(SWOVER_ADDR, 8'h02);
        check(8'(swover_n), 8'h00);
        wr_reg(SWOVER_ADDR, SWOVER_CLR);
        check(8'(swover_n), 8'h01);
        wr_reg(FIFO_CLR_ADDR, 8'h00);
        check({6'h00, tx_clr, rx_clr}, 8'h01);
        rd_reg(FIFO_CLR_ADDR, d);
        check({6'h00, tx_clr, rx_clr}, 8'h02);
        rd_reg(16'h4d03, d);
        check(d, 8'h00);
        rd_reg(STAT_ADDR, d);
        check({d[STAT_MASTER], dis_n, 6'h00}, 8'hc0);
    endtask
    task automatic t_proto();
        rd_reg(STAT_ADDR, d);
        check({5'h00, d[2:0]}, {5'h00, XFER_RESET_STATE});
        foreach (STEPS[i]) begin
            if (STEPS[i][5]) wr_reg(CTRL_ADDR, {6'h01, STEPS[i][4:3]});
            u_line.send(STEPS[i][5] ? 2'b00 : STEPS[i][4:3]);
            repeat (6) @(posedge clk);
            rd_reg(STAT_ADDR, d);
            check({5'h00, d[2:0]}, {5'h00, STEPS[i][2:0]});
            check(8'(err), 8'(STEPS[i][2:0] == XFER_ABORT_STATE));
            if (STEPS[i][5]) begin
                check({la_oe, lb_oe, lb_o, la_o},
                      {2'b11, STEPS[i][4:3], STEPS[i][4:3]});
            end
        end
        wr_reg(CTRL_ADDR, 8'h08);
        check(8'(err), 8'h00);
        u_line.send(2'b01);
        repeat (6) @(posedge clk);
        rd_reg(STAT_ADDR, d);
        check({5'h00, d[2:0]}, {5'h00, XFER_IDLE_STATE});
    endtask
    task automatic t_switch();
        @(posedge clk) swap <= 1'b1;
        @(posedge clk) swap <= 1'b0;
        repeat (4) @(posedge clk);
        check(8'(master_n), 8'h00);
        swap_roles();
        check({dis_n, la_oe, lb_oe, dma, swover_n}, 8'h01);
        rd_reg(STAT_ADDR, d);
        check(8'(d[STAT_MASTER]), 8'h00);
        swap_roles();
        check({dis_n, dma}, 8'h02);
        wr_reg(CTRL_ADDR, 8'h10);
        repeat (2) @(posedge clk);
        check(8'(dma), 8'h01);
    endtask
    task automatic t_hold();
        @(posedge clk) cpu_nrdy_n <= 1'b1;
        repeat (20) @(posedge clk);
        check({por_n, basic}, 8'h03);
        @(posedge clk) cpu_nrdy_n <= 1'b0;
        wait_basic();
    endtask
    task automatic t_fault();
        @(posedge clk) fault <= 1'b1;
        repeat (8) @(posedge clk);
        check({fault_n, dis_n, la_oe, lb_oe}, 8'h00);
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) fault <= 1'b0;
        #1 check({por_n, fault_n, basic}, 8'h03);
        @(posedge clk) rst <= 1'b0;
        wait_basic();
        check({por_n, fault_n}, 8'h03);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {rst, wr, rd, addr, wdata, cpu_nrdy_n, fault, swap} = '0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wait_basic();
        wait_basic();
        t_regs();
        t_proto();
        t_switch();
        t_hold();
        t_fault();
        give_verdict();
    end
    // watchdog against a hang
    initial begin
        #100us;
        failures++;
        give_verdict();
    end
endmodule // test_rlp_ctrl
